// ### rtl/css_defines.svh
// Constants for the system clock source switcher: offsets, fields, codes, counts.
// Assumes inclusion from the switcher package, the top module and the bench only.
`ifndef CSS_DEFINES_SVH
`define CSS_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define CSS_ADDR_OSC_CTRL 4'h0
`define CSS_ADDR_T1_CTRL 4'h4
`define CSS_ADDR_STATUS 4'h8

// ****************************************
// Field positions and reset values
// ****************************************
`define CSS_SEL_LSB 0
`define CSS_IFS_FLAG_BIT 2
`define CSS_OST_FLAG_BIT 3
`define CSS_IFS_LSB 4
`define CSS_SEC_EN_BIT 0
`define CSS_SECONDARY_RUN_MODE_BIT 1
`define CSS_SEL_RESET 2'h0
`define CSS_IFS_RESET 3'h0

// ****************************************
// Source and primary configuration codes
// ****************************************
`define CSS_SRC_PRIM 2'h0
`define CSS_SRC_SEC 2'h1
`define CSS_SRC_INT 2'h2
`define CSS_SRC_RSV 2'h3
`define CSS_CFG_LP 3'h0
`define CSS_CFG_XT 3'h1
`define CSS_CFG_HS 3'h2
`define CSS_CFG_EC 3'h3
`define CSS_CFG_RC 3'h4
`define CSS_CFG_SLOW 3'h5

// ****************************************
// Timing
// ****************************************
`define CSS_OST_CYCLES 1024
`define CSS_HOLD_EDGES 8
`define CSS_CLK_MHZ 50
`define CSS_CPU_DLY_NS 5000
`define CSS_CPU_CYC ((`CSS_CPU_DLY_NS * `CSS_CLK_MHZ + 999) / 1000)
`define CSS_FAST_SETTLE_US 4000
`define CSS_FAST_CYC (`CSS_FAST_SETTLE_US * `CSS_CLK_MHZ)
`define CSS_CNT_W 11
`define CSS_FAST_W 18

`endif

// ### rtl/css_pkg.sv
// Types for the system clock source switcher.
// Assumes the defines header for field widths.
`include "css_defines.svh"

package css_pkg;

  typedef enum logic [4:0] {
    CSS_ST_RUN = 5'b00001,
    CSS_ST_OST = 5'b00010,
    CSS_ST_WLOW = 5'b00100,
    CSS_ST_HOLD8 = 5'b01000,
    CSS_ST_CPU = 5'b10000
  } css_state_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [1:0] sel;
    logic [2:0] ifs;
    logic ost_flag;
    logic ifs_flag;
    logic sec_en;
    logic [1:0] cur;
    logic [1:0] tgt;
    logic [1:0] from_src;
    css_state_t st;
    logic [`CSS_CNT_W-1:0] cnt;
    logic fast_run;
    logic [`CSS_FAST_W-1:0] fast_cnt;
    logic wake;
    logic [3:0] osc_prev;
    logic clk_out;
    logic hold_low;
    logic core_hold;
    logic prim_pwr;
    logic sec_pwr;
  } css_regs_t;

endpackage

// ### rtl/css_switcher.sv
// System clock source switcher: selects primary, secondary or internal source.
// Assumes oscillator inputs sampled synchronously to sys_clk, Avalon-MM master.
//
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "css_defines.svh"

// Operation
// - Wake into slow or secondary: 5us CPU delay
// - Wake into crystal primary: count 1024 cycles
// - Select internal: clear timeout flag, switch, power primary down
// - Primary already slow internal: no switch
// - Fast internal from other source: stable after 4ms
// - Hold first phase for eight internal edges
// - Select secondary: clear flag, switch, power primary down
// - Hold first phase for eight secondary edges
// - Secondary active flag set while secondary drives
// - Enable clear: 01 gives 00, 11 gives 10
// - Switch only when select value differs
// - Return to crystal primary waits 1024 cycles
// - During start-up count keep current clock
// - Timeout flag set once running from primary
// - After start-up hold eight primary edges
// - Clearing secondary enable clears select low bit
// - Secondary stays powered until switch completes
// - Leaving secondary for ec/rc: CPU delay
// - Select codes: 00 primary, 01 secondary, 10 internal
// - Reset returns select to 00
module css_switcher
  import css_pkg::*;
#(
  parameter int FAST_SETTLE_CYC = `CSS_FAST_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Oscillators and configuration
  input wire logic prim_osc_in,
  input wire logic sec_osc_in,
  input wire logic slow_osc_in,
  input wire logic fast_osc_in,
  input wire logic [2:0] prim_osc_config,
  input wire logic wake_pulse,
  // Clock result and controls
  output logic sys_clk_out,
  output logic core_hold,
  output logic prim_osc_power_en,
  output logic sec_osc_power_en,
  output logic startup_timeout_flag,
  output logic fast_internal_stable_flag,
  output logic secondary_clock_active_flag
);

  localparam logic [`CSS_CNT_W-1:0] OST_LAST = `CSS_CNT_W'(`CSS_OST_CYCLES - 1);
  localparam logic [`CSS_CNT_W-1:0] HOLD_LAST = `CSS_CNT_W'(`CSS_HOLD_EDGES - 1);
  localparam logic [`CSS_CNT_W-1:0] CPU_LAST = `CSS_CNT_W'(`CSS_CPU_CYC - 1);
  localparam logic [`CSS_FAST_W-1:0] FAST_LAST = `CSS_FAST_W'(FAST_SETTLE_CYC - 1);

  css_regs_t r_ff;
  css_regs_t nxt_r;
  logic [3:0] osc_in;
  logic bus_req;
  logic bus_wr;
  logic [31:0] rd_mux;
  logic [1:0] cur_idx;
  logic fall_cur;
  logic fall_prim;

  assign osc_in = {fast_osc_in, slow_osc_in, sec_osc_in, prim_osc_in};

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [1:0] src_idx(input logic [1:0] src, input logic [2:0] ifs,
                                         input logic [2:0] cfg);
    logic [1:0] idx;
    idx = 2'h0;
    case (src)
      `CSS_SRC_SEC: idx = 2'h1;
      `CSS_SRC_INT: idx = (ifs == 3'h0) ? 2'h2 : 2'h3;
      default: idx = (cfg == `CSS_CFG_SLOW) ? 2'h2 : 2'h0;
    endcase
    return idx;
  endfunction

  function automatic logic is_xtal(input logic [2:0] cfg);
    return (cfg == `CSS_CFG_LP) || (cfg == `CSS_CFG_XT) || (cfg == `CSS_CFG_HS);
  endfunction

  function automatic logic is_ecrc(input logic [2:0] cfg);
    return (cfg == `CSS_CFG_EC) || (cfg == `CSS_CFG_RC);
  endfunction

  assign cur_idx = src_idx(r_ff.cur, r_ff.ifs, prim_osc_config);
  assign fall_cur = r_ff.osc_prev[cur_idx] & ~osc_in[cur_idx];
  assign fall_prim = r_ff.osc_prev[0] & ~osc_in[0];

  // ****************************************
  // Bus slave
  // ****************************************
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~r_ff.ack;
  assign bus_wr = avs_write & r_ff.ack & avs_byteenable[0];

  always_comb begin
    rd_mux = 32'h0;
    case (avs_address)
      `CSS_ADDR_OSC_CTRL: begin
        rd_mux[`CSS_IFS_LSB +: 3] = r_ff.ifs;
        rd_mux[`CSS_OST_FLAG_BIT] = r_ff.ost_flag;
        rd_mux[`CSS_IFS_FLAG_BIT] = r_ff.ifs_flag;
        rd_mux[`CSS_SEL_LSB +: 2] = r_ff.sel;
      end
      `CSS_ADDR_T1_CTRL: begin
        rd_mux[`CSS_SEC_EN_BIT] = r_ff.sec_en;
        rd_mux[`CSS_SECONDARY_RUN_MODE_BIT] = (r_ff.cur == `CSS_SRC_SEC);
      end
      `CSS_ADDR_STATUS: begin
        rd_mux[0] = (r_ff.st != CSS_ST_RUN);
        rd_mux[2:1] = r_ff.cur;
        rd_mux[3] = r_ff.core_hold;
      end
      default: rd_mux = 32'h0;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [1:0] wsel;
    logic no_switch;
    wsel = 2'h0;
    nxt_r = r_ff;
    no_switch = 1'b0;
    nxt_r.osc_prev = osc_in;
    nxt_r.ack = bus_req & ~r_ff.ack;
    if (bus_req && !r_ff.ack) begin
      nxt_r.rdata = rd_mux;
    end

    // Settling timer of the fast internal source
    if (r_ff.fast_run) begin
      if (r_ff.fast_cnt == FAST_LAST) begin
        nxt_r.fast_run = 1'b0;
        nxt_r.ifs_flag = 1'b1;
      end else begin
        nxt_r.fast_cnt = r_ff.fast_cnt + `CSS_FAST_W'(1);
      end
    end

    // Register writes
    if (bus_wr && avs_address == `CSS_ADDR_OSC_CTRL) begin
      wsel = avs_writedata[`CSS_SEL_LSB +: 2];
      if (wsel == `CSS_SRC_RSV) begin
        nxt_r.sel = `CSS_SRC_INT;
      end else if (!r_ff.sec_en) begin
        nxt_r.sel = {wsel[1], 1'b0};
      end else begin
        nxt_r.sel = wsel;
      end
      nxt_r.ifs = avs_writedata[`CSS_IFS_LSB +: 3];
      if (r_ff.ifs == 3'h0 && avs_writedata[`CSS_IFS_LSB +: 3] != 3'h0 &&
          r_ff.cur == `CSS_SRC_INT) begin
        nxt_r.ifs_flag = 1'b0;
        nxt_r.fast_run = 1'b1;
        nxt_r.fast_cnt = '0;
      end
    end
    if (bus_wr && avs_address == `CSS_ADDR_T1_CTRL) begin
      nxt_r.sec_en = avs_writedata[`CSS_SEC_EN_BIT];
      if (!avs_writedata[`CSS_SEC_EN_BIT]) begin
        nxt_r.sel[0] = 1'b0;
      end
    end

    // Switch sequencer
    case (r_ff.st)
      CSS_ST_RUN: begin
        no_switch = (r_ff.sel == `CSS_SRC_INT) && (r_ff.cur == `CSS_SRC_PRIM) &&
                    (prim_osc_config == `CSS_CFG_SLOW) && (r_ff.ifs == 3'h0);
        if (wake_pulse) begin
          nxt_r.wake = 1'b1;
          nxt_r.core_hold = 1'b1;
          nxt_r.cnt = '0;
          if (r_ff.cur == `CSS_SRC_PRIM && is_xtal(prim_osc_config)) begin
            nxt_r.ost_flag = 1'b0;
            nxt_r.st = CSS_ST_OST;
          end else begin
            nxt_r.st = CSS_ST_CPU;
            if (r_ff.cur == `CSS_SRC_INT && r_ff.ifs != 3'h0) begin
              nxt_r.ifs_flag = 1'b0;
              nxt_r.fast_run = 1'b1;
              nxt_r.fast_cnt = '0;
            end
          end
        end else if (r_ff.sel != r_ff.cur && !no_switch) begin
          nxt_r.tgt = r_ff.sel;
          nxt_r.cnt = '0;
          if (r_ff.sel != `CSS_SRC_PRIM) begin
            nxt_r.ost_flag = 1'b0;
            nxt_r.st = CSS_ST_WLOW;
          end else if (is_xtal(prim_osc_config)) begin
            nxt_r.st = CSS_ST_OST;
          end else begin
            nxt_r.st = CSS_ST_WLOW;
          end
        end
      end
      CSS_ST_OST: begin
        // Current source keeps clocking the core meanwhile
        if (fall_prim) begin
          if (r_ff.cnt == OST_LAST) begin
            nxt_r.cnt = '0;
            if (r_ff.wake) begin
              nxt_r.wake = 1'b0;
              nxt_r.core_hold = 1'b0;
              nxt_r.ost_flag = 1'b1;
              nxt_r.st = CSS_ST_RUN;
            end else begin
              nxt_r.st = CSS_ST_WLOW;
            end
          end else begin
            nxt_r.cnt = r_ff.cnt + `CSS_CNT_W'(1);
          end
        end
      end
      CSS_ST_WLOW: begin
        if (fall_cur) begin
          nxt_r.hold_low = 1'b1;
          nxt_r.core_hold = 1'b1;
          nxt_r.from_src = r_ff.cur;
          nxt_r.cur = r_ff.tgt;
          nxt_r.cnt = '0;
          nxt_r.st = CSS_ST_HOLD8;
        end
      end
      CSS_ST_HOLD8: begin
        if (fall_cur) begin
          if (r_ff.cnt == HOLD_LAST) begin
            nxt_r.hold_low = 1'b0;
            nxt_r.cnt = '0;
            if (r_ff.cur == `CSS_SRC_PRIM) begin
              nxt_r.ost_flag = 1'b1;
            end
            if (r_ff.cur == `CSS_SRC_INT && r_ff.ifs != 3'h0 &&
                r_ff.from_src != `CSS_SRC_INT) begin
              nxt_r.ifs_flag = 1'b0;
              nxt_r.fast_run = 1'b1;
              nxt_r.fast_cnt = '0;
            end
            if (r_ff.from_src == `CSS_SRC_SEC && r_ff.cur == `CSS_SRC_PRIM &&
                is_ecrc(prim_osc_config)) begin
              nxt_r.st = CSS_ST_CPU;
            end else begin
              nxt_r.core_hold = 1'b0;
              nxt_r.st = CSS_ST_RUN;
            end
          end else begin
            nxt_r.cnt = r_ff.cnt + `CSS_CNT_W'(1);
          end
        end
      end
      CSS_ST_CPU: begin
        if (r_ff.cnt == CPU_LAST) begin
          nxt_r.cnt = '0;
          nxt_r.core_hold = 1'b0;
          nxt_r.wake = 1'b0;
          if (r_ff.cur == `CSS_SRC_PRIM) begin
            nxt_r.ost_flag = 1'b1;
          end
          nxt_r.st = CSS_ST_RUN;
        end else begin
          nxt_r.cnt = r_ff.cnt + `CSS_CNT_W'(1);
        end
      end
      default: begin
        nxt_r.st = CSS_ST_RUN;
        nxt_r.hold_low = 1'b0;
        nxt_r.core_hold = 1'b0;
      end
    endcase

    // Clock result and oscillator power
    nxt_r.clk_out = nxt_r.hold_low ? 1'b0 :
                    osc_in[src_idx(nxt_r.cur, nxt_r.ifs, prim_osc_config)];
    nxt_r.prim_pwr = (nxt_r.cur == `CSS_SRC_PRIM) ||
                     (nxt_r.st != CSS_ST_RUN && nxt_r.tgt == `CSS_SRC_PRIM);
    nxt_r.sec_pwr = nxt_r.sec_en || (nxt_r.cur == `CSS_SRC_SEC);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r_ff <= '{ack: 1'b0, rdata: 32'h0, sel: `CSS_SEL_RESET, ifs: `CSS_IFS_RESET,
                ost_flag: 1'b0, ifs_flag: 1'b0, sec_en: 1'b0, cur: `CSS_SRC_PRIM,
                tgt: `CSS_SRC_PRIM, from_src: `CSS_SRC_PRIM, st: CSS_ST_RUN,
                cnt: '0, fast_run: 1'b0, fast_cnt: '0, wake: 1'b0, osc_prev: 4'h0,
                clk_out: 1'b0, hold_low: 1'b0, core_hold: 1'b0, prim_pwr: 1'b1,
                sec_pwr: 1'b0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign avs_readdata = r_ff.rdata;
  assign sys_clk_out = r_ff.clk_out;
  assign core_hold = r_ff.core_hold;
  assign prim_osc_power_en = r_ff.prim_pwr;
  assign sec_osc_power_en = r_ff.sec_pwr;
  assign startup_timeout_flag = r_ff.ost_flag;
  assign fast_internal_stable_flag = r_ff.ifs_flag;
  assign secondary_clock_active_flag = (r_ff.cur == `CSS_SRC_SEC);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_mux_while_low: assert property ($changed(r_ff.cur) |-> r_ff.hold_low && !sys_clk_out)
    else $error("source changed while clock not held low");
  a_sec_active: assert property ((r_ff.st == CSS_ST_HOLD8 && r_ff.tgt == `CSS_SRC_SEC)
    |-> secondary_clock_active_flag)
    else $error("secondary active flag missing");
  a_flag_cleared: assert property ((r_ff.st == CSS_ST_RUN && nxt_r.st == CSS_ST_WLOW &&
    r_ff.sel != `CSS_SRC_PRIM) |=> !startup_timeout_flag)
    else $error("timeout flag not cleared on switch away");
  a_sel_reserved: assert property ((bus_wr && avs_address == `CSS_ADDR_OSC_CTRL &&
    avs_writedata[1:0] == 2'h3) |=> r_ff.sel == `CSS_SRC_INT)
    else $error("reserved select not mapped");
  a_sel_no_sec: assert property ((bus_wr && avs_address == `CSS_ADDR_OSC_CTRL &&
    !r_ff.sec_en && avs_writedata[1:0] == 2'h1) |=> r_ff.sel == 2'h0)
    else $error("secondary selected without enable");
  a_hold_core: assert property (r_ff.hold_low |-> core_hold)
    else $error("core not held during edge count");
  a_ost_keep_clk: assert property ((r_ff.st == CSS_ST_OST && !r_ff.wake)
    |-> !r_ff.hold_low && prim_osc_power_en)
    else $error("current clock not kept during start-up count");
  a_ost_bound: assert property (r_ff.st == CSS_ST_OST |-> r_ff.cnt <= OST_LAST)
    else $error("start-up count overrun");
  a_cpu_delay: assert property ($rose(r_ff.st == CSS_ST_CPU) |-> core_hold[*8])
    else $error("cpu delay too short");
  a_sec_power: assert property (secondary_clock_active_flag |-> sec_osc_power_en)
    else $error("secondary powered down while in use");
  a_fast_pending: assert property (r_ff.fast_run |-> !fast_internal_stable_flag)
    else $error("fast stable flag set early");
  a_same_osc: assert property ((r_ff.st == CSS_ST_RUN && r_ff.sel == `CSS_SRC_INT &&
    r_ff.cur == `CSS_SRC_PRIM && prim_osc_config == `CSS_CFG_SLOW && r_ff.ifs == 3'h0 &&
    !wake_pulse) |=> r_ff.st == CSS_ST_RUN)
    else $error("switch on identical oscillator");

  c_to_sec: cover property (r_ff.st == CSS_ST_HOLD8 && r_ff.cur == `CSS_SRC_SEC ##1
    r_ff.st == CSS_ST_RUN);
  c_to_xtal: cover property (r_ff.st == CSS_ST_OST && !r_ff.wake ##[1:1000]
    r_ff.st == CSS_ST_WLOW);
  c_wake: cover property ($rose(r_ff.wake));
  c_fast_done: cover property ($rose(fast_internal_stable_flag));

endmodule
`default_nettype wire

// ### verif/css_osc_model.sv
// Oscillator sources in front of the clock source switcher.
// Assumes sys_clk steps all sources; a powered-down crystal rests low.
`timescale 1ns/1ns
`default_nettype none
module css_osc_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Power controls
  input wire logic prim_pwr,
  input wire logic sec_pwr,
  // Oscillator outputs
  output logic prim_osc,
  output logic sec_osc,
  output logic slow_osc,
  output logic fast_osc
);
  logic [3:0] div_ff;
  // Periods: primary 4, secondary 8, slow 16, fast 2 cycles
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_ff <= 4'h0;
      prim_osc <= 1'b0;
      sec_osc <= 1'b0;
      slow_osc <= 1'b0;
      fast_osc <= 1'b0;
    end else begin
      div_ff <= div_ff + 4'h1;
      prim_osc <= div_ff[1] & prim_pwr;
      sec_osc <= div_ff[2] & sec_pwr;
      slow_osc <= div_ff[3];
      fast_osc <= div_ff[0];
    end
  end
endmodule
`default_nettype wire

// ### verif/test_css_switcher.sv
// Self-checking bench for the clock source switcher.
// Assumes the oscillator model as far side and a 50 MHz sys_clk.
`timescale 1ns/1ns
`default_nettype none
`include "css_defines.svh"
module test_css_switcher import css_pkg::*;;
  localparam int FAST = 50;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic prim_osc, sec_osc, slow_osc, fast_osc;
  logic [2:0] cfg = 3'h1;
  logic wake_pulse = 1'b0;
  logic sys_clk_out, core_hold, prim_pwr, sec_pwr, ost_flag, fast_flag, sec_act;
  int errors = 0;
  int cmp_count = 0;
  int hold_cnt = 0;
  logic [31:0] q;

  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (core_hold === 1'b1) hold_cnt <= hold_cnt + 1;

  css_switcher #(.FAST_SETTLE_CYC(FAST)) u_css_switcher (
    .sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .prim_osc_in(prim_osc), .sec_osc_in(sec_osc),
    .slow_osc_in(slow_osc), .fast_osc_in(fast_osc), .prim_osc_config(cfg),
    .wake_pulse(wake_pulse), .sys_clk_out(sys_clk_out), .core_hold(core_hold),
    .prim_osc_power_en(prim_pwr), .sec_osc_power_en(sec_pwr),
    .startup_timeout_flag(ost_flag), .fast_internal_stable_flag(fast_flag),
    .secondary_clock_active_flag(sec_act));

  css_osc_model u_css_osc_model (
    .sys_clk(sys_clk), .arst_n(arst_n), .prim_pwr(prim_pwr), .sec_pwr(sec_pwr),
    .prim_osc(prim_osc), .sec_osc(sec_osc), .slow_osc(slow_osc), .fast_osc(fast_osc));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    check(n, 32'h2);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      bus(1'b0, 4'h8, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 5000);
    check(n < 5000, 1);
  endtask

  task automatic hold_in(input int h0, input int lo, input int hi);
    check(hold_cnt - h0 >= lo && hold_cnt - h0 <= hi, 1);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    bus(1'b0, 4'h0, 32'h0);
    check(q, 32'h0);
    bus(1'b0, 4'h4, 32'h0);
    check(q, 32'h0);
    bus(1'b0, 4'hc, 32'h0);
    check(q, 32'h0);
    check({prim_pwr, sec_pwr, ost_flag, sec_act}, 4'h8);
  endtask

  task automatic t_to_int();
    int h;
    bus(1'b1, 4'h0, 32'h1);
    bus(1'b0, 4'h0, 32'h0);
    check(q[1:0], 2'h0);
    bus(1'b0, 4'h8, 32'h0);
    check(q[2:0], 3'h0);
    h = hold_cnt;
    bus(1'b1, 4'h0, 32'h3);
    bus(1'b0, 4'h0, 32'h0);
    check(q[1:0], 2'h2);
    wait_idle();
    check(q[2:1], 2'h2);
    check({ost_flag, prim_pwr}, 2'h0);
    hold_in(h, 112, 170);
    bus(1'b1, 4'h0, 32'h3);
    bus(1'b0, 4'h8, 32'h0);
    check(q[0], 1'b0);
  endtask

  task automatic t_to_prim();
    int n, tg, h;
    logic last;
    n = 0;
    tg = 0;
    last = sys_clk_out;
    bus(1'b1, 4'h0, 32'h0);
    while (core_hold !== 1'b1 && n < 8000) begin
      @(posedge sys_clk);
      n++;
      if (sys_clk_out !== last) tg++;
      last = sys_clk_out;
    end
    check(n >= 4090 && n < 8000, 1);
    check(tg > 100, 1);
    check(ost_flag, 1'b0);
    h = hold_cnt;
    wait_idle();
    check(q[2:1], 2'h0);
    check(ost_flag, 1'b1);
    hold_in(h, 20, 48);
  endtask

  task automatic t_sec(input logic [2:0] c, input int lo, input int hi);
    int h;
    cfg <= c;
    bus(1'b1, 4'h4, 32'h1);
    repeat (40) @(posedge sys_clk);
    h = hold_cnt;
    bus(1'b1, 4'h0, 32'h1);
    wait_idle();
    check(q[2:1], 2'h1);
    check({sec_act, ost_flag, prim_pwr}, 3'h4);
    hold_in(h, 56, 100);
    h = hold_cnt;
    bus(1'b1, 4'h4, 32'h0);
    @(posedge sys_clk);
    check({sec_pwr, sec_act}, 2'h3);
    bus(1'b0, 4'h0, 32'h0);
    check(q[1:0], 2'h0);
    wait_idle();
    check({sec_pwr, sec_act, ost_flag}, 3'h1);
    hold_in(h, lo, hi);
  endtask

  task automatic t_same_slow();
    cfg <= 3'h5;
    bus(1'b1, 4'h0, 32'h2);
    bus(1'b0, 4'h8, 32'h0);
    check(q[2:0], 3'h0);
    bus(1'b1, 4'h0, 32'h0);
    cfg <= 3'h1;
  endtask

  task automatic t_fast();
    bus(1'b1, 4'h0, 32'h32);
    wait_idle();
    check(fast_flag, 1'b0);
    repeat (FAST - 20) @(posedge sys_clk);
    check(fast_flag, 1'b0);
    repeat (30) @(posedge sys_clk);
    check(fast_flag, 1'b1);
    bus(1'b1, 4'h0, 32'h0);
    wait_idle();
  endtask

  task automatic t_wake(input logic [2:0] c, input int lo, input int hi);
    int h;
    cfg <= c;
    @(posedge sys_clk);
    h = hold_cnt;
    wake_pulse <= 1'b1;
    @(posedge sys_clk);
    wake_pulse <= 1'b0;
    wait_idle();
    hold_in(h, lo, hi);
    check(ost_flag, 1'b1);
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    errors++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset();
    t_to_int();
    t_to_prim();
    t_sec(3'h1, 20, 48);
    t_sec(3'h3, 278, 340);
    t_same_slow();
    t_fast();
    t_wake(3'h1, 4090, 4200);
    t_wake(3'h3, 250, 252);
    end_of_test();
  end
endmodule
`default_nettype wire
